/* src/pcpg_defines.svh */
// Constants for the power-good and configuration register group.
// Notes on behaviour
// [R1] Start-up delay step is 0.5 ms when range bit is 0, 1 ms when 1.
// [R2] Shutdown delay step is 0.5 ms when range bit is 0, 1 ms when 1.
// [R3] Clock-input pin is second general output or clock input; pull-down applies to both.
// [R4] Enable-pin pull-down follows its configuration bit.
// [R5] Thermal warning threshold select: 0 gives 125 C, 1 gives 137 C.
// [R6] Spread spectrum modulation runs only while its enable bit is 1.
// [R7] With PLL bit clear, PLL is off and the internal oscillator is always used.
// [R8] With PLL bit set, external clock used when present; appearance or loss raises event.
// [R9] Host writes 0 to reserved bit 5 of the external clock register.
// [R10] Frequency code means code plus one MHz; codes 0x18 to 0x1F are reserved.
// [R11] Power-good is high for valid outputs at polarity 0, low at polarity 1.
// [R12] Power-good is push-pull when drive bit is 0, open-drain when 1.
// [R13] Window bit 0 checks undervoltage only; 1 checks over- and undervoltage.
// [R14] Each regulator is monitored only while its source bit is set.
// [R15] Thermal gate bit forces power-good inactive during a thermal warning.
// [R16] Fault-gate bit selects live status or the latched faults for power-good.
// [R17] Run mode bit 0 selects gated mode, 1 continuous mode.
// [R18] Delay codes run 0x0 to 0xF; delay is code times step from enable edge.
// [R19] Fault latch sets on a monitored failure; write 1 clears once output is valid.
// [R20] External clock event sets a sticky status bit cleared by writing 1.
// [R21] Configuration values load from nonvolatile storage at reset and software reset.
`ifndef PCPG_DEFINES_SVH
`define PCPG_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCPG_ADDR_DEVICE_CONFIG 8'h13
`define PCPG_ADDR_EXT_CLOCK 8'h14
`define PCPG_ADDR_PG_OUTPUT 8'h15
`define PCPG_ADDR_PG_GATING 8'h16
`define PCPG_ADDR_POWER_GOOD_FAULT_LATCHES 8'h17
`define PCPG_ADDR_SW_RESET 8'h18
`define PCPG_ADDR_INT_STATUS 8'h19

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCPG_CFG_STARTUP_RANGE 6
`define PCPG_CFG_SHUTDOWN_RANGE 5
`define PCPG_CFG_EXTERNAL_CLOCK_PIN_SEL 4
`define PCPG_CFG_EXTERNAL_CLOCK_PIN_PULLDOWN_ENABLE 3
`define PCPG_CFG_ENABLE_PIN_PULLDOWN 2
`define PCPG_CFG_TWARN_LEVEL 1
`define PCPG_CFG_SPREAD 0
`define PCPG_PLL_ENABLE 6
`define PCPG_PG1_POLARITY 7
`define PCPG_PG1_OPEN_DRAIN 6
`define PCPG_PG1_WINDOW 4
`define PCPG_PG2_THERMAL_GATE 2
`define PCPG_PG2_FAULT_GATE 1
`define PCPG_PG2_RUN_MODE 0
`define PCPG_INT_SYNC_CLK 4
`define PCPG_SW_RESET_BIT 0

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define PCPG_MASK_CONFIG 8'h7f
`define PCPG_MASK_EXT_CLOCK 8'h5f
`define PCPG_MASK_PG_OUTPUT 8'hd3
`define PCPG_MASK_PG_GATING 8'h07

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCPG_CLK_PERIOD_NS 50
`define PCPG_DELAY_STEP_NS 500000
`define PCPG_DELAY_STEP_CYCLES (`PCPG_DELAY_STEP_NS / `PCPG_CLK_PERIOD_NS)
`define PCPG_EXT_CLK_LOSS_NS 2000
`define PCPG_EXT_CLK_LOSS_CYCLES (`PCPG_EXT_CLK_LOSS_NS / `PCPG_CLK_PERIOD_NS)

`endif

/* src/pcpg_pkg.sv */
// Types shared by the register group.
package pcpg_pkg;

  typedef enum logic [3:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ACK_ADDR,
    I2C_REG,
    I2C_ACK_REG,
    I2C_WDATA,
    I2C_ACK_W,
    I2C_RDATA,
    I2C_ACK_R
  } pcpg_i2c_state_t;

endpackage

/* src/pcpg_delay_timer.sv */
// Start-up and shutdown delay timer for one regulator.
`timescale 1ns/1ps
`default_nettype none

module pcpg_delay_timer #(
  parameter logic [15:0] STEP_CYCLES = 16'h2710
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic [3:0] startup_code_in,
  input wire logic [3:0] shutdown_code_in,
  input wire logic startup_range_in,
  input wire logic shutdown_range_in,
  output logic on_out
);

  logic prev;
  logic busy;
  logic long_step;
  logic [3:0] steps;
  logic [16:0] pre;
  wire logic [16:0] limit;

  // One code step lasts one or two base steps.
  assign limit = long_step ? {STEP_CYCLES, 1'b0} : {1'b0, STEP_CYCLES};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prev <= 1'b0;
      busy <= 1'b0;
      long_step <= 1'b0;
      steps <= 4'h0;
      pre <= 17'h0_0000;
      on_out <= 1'b0;
    end else begin
      prev <= enable_in;
      if (enable_in != prev) begin
        busy <= 1'b1;
        pre <= 17'h0_0000;
        steps <= enable_in ? startup_code_in : shutdown_code_in; // [R18]
        long_step <= enable_in ? startup_range_in : shutdown_range_in; // [R1] [R2]
      end else if (busy) begin
        if (steps == 4'h0) begin
          on_out <= prev;
          busy <= 1'b0;
        end else if (pre == limit - 17'h0_0001) begin
          pre <= 17'h0_0000;
          steps <= steps - 4'h1;
        end else begin
          pre <= pre + 17'h0_0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* src/pcpg_regs.sv */
// Serial-bus register group with power-good and clock-input control.
`timescale 1ns/1ps
`default_nettype none
`include "pcpg_defines.svh"

module pcpg_regs #(
  parameter logic [6:0] I2C_ADDRESS = 7'h2a,
  parameter logic [15:0] DELAY_STEP_CYCLES = 16'(`PCPG_DELAY_STEP_CYCLES)
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_out,
  input wire logic [7:0] nvm_config_in,
  input wire logic [7:0] nvm_ext_clock_in,
  input wire logic [7:0] nvm_pg_output_in,
  input wire logic [7:0] nvm_pg_gating_in,
  input wire logic [15:0] delay_codes_in,
  input wire logic enable_pin_in,
  input wire logic [1:0] reg_undervoltage_in,
  input wire logic [1:0] reg_overvoltage_in,
  input wire logic thermal_warn_in,
  input wire logic external_clock_pin_in,
  input wire logic general_output_two_level_in,
  output logic external_clock_pin_out,
  output logic external_clock_pin_oe_out,
  output logic external_clock_pin_pulldown_enable_out,
  output logic enable_pin_pulldown_out,
  output logic thermal_warn_level_out,
  output logic spread_spectrum_enable_out,
  output logic ext_clock_pll_enable_out,
  output logic ext_clock_select_out,
  output logic [4:0] ext_clock_frequency_out,
  output logic sync_clock_event_out,
  output logic [1:0] regulator_enable_out,
  output logic [1:0] power_good_fault_latches_out,
  output logic power_good_output_out,
  output logic power_good_output_oe_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 9;
  // Bus lines idle high, all other pins idle low, so no false edge follows reset.
  localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h180;
  wire logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic scl_d;
  logic sda_d;
  logic clk_d;

  assign raw_in = {i2c_scl_in, i2c_sda_in, external_clock_pin_in, enable_pin_in,
                   reg_undervoltage_in, reg_overvoltage_in, thermal_warn_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          sync_a[gi] <= SYNC_IDLE[gi];
          sync_b[gi] <= SYNC_IDLE[gi];
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire logic scl_s = sync_b[8];
  wire logic sda_s = sync_b[7];
  wire logic ext_clk_s = sync_b[6];
  wire logic enable_s = sync_b[5];
  wire logic [1:0] uv_s = sync_b[4:3];
  wire logic [1:0] ov_s = sync_b[2:1];
  wire logic twarn_s = sync_b[0];

  wire logic scl_rise = scl_s & ~scl_d;
  wire logic scl_fall = ~scl_s & scl_d;
  wire logic bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire logic bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Serial bus slave
  // ----------------------------------------------------------------
  pcpg_pkg::pcpg_i2c_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic rw;
  logic wr_stb;
  wire logic [7:0] rd_data;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      clk_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      clk_d <= ext_clk_s;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= pcpg_pkg::I2C_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      wr_stb <= 1'b0;
      i2c_sda_oe_out <= 1'b0;
      i2c_sda_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_stop) begin
        state <= pcpg_pkg::I2C_IDLE;
        i2c_sda_oe_out <= 1'b0;
      end else if (bus_start) begin
        state <= pcpg_pkg::I2C_ADDR;
        bitcnt <= 4'h0;
        i2c_sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        shift <= {shift[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end else if (scl_fall) begin
        case (state)
          pcpg_pkg::I2C_ADDR: begin
            if (bitcnt == 4'h8) begin
              if (shift[7:1] == I2C_ADDRESS) begin
                rw <= shift[0];
                i2c_sda_oe_out <= 1'b1;
                state <= pcpg_pkg::I2C_ACK_ADDR;
              end else begin
                state <= pcpg_pkg::I2C_IDLE;
              end
            end
          end
          pcpg_pkg::I2C_ACK_ADDR: begin
            bitcnt <= 4'h0;
            if (rw) begin
              tx <= rd_data;
              i2c_sda_oe_out <= ~rd_data[7];
              state <= pcpg_pkg::I2C_RDATA;
            end else begin
              i2c_sda_oe_out <= 1'b0;
              state <= pcpg_pkg::I2C_REG;
            end
          end
          pcpg_pkg::I2C_REG: begin
            if (bitcnt == 4'h8) begin
              ptr <= shift;
              i2c_sda_oe_out <= 1'b1;
              state <= pcpg_pkg::I2C_ACK_REG;
            end
          end
          pcpg_pkg::I2C_ACK_REG: begin
            bitcnt <= 4'h0;
            i2c_sda_oe_out <= 1'b0;
            state <= pcpg_pkg::I2C_WDATA;
          end
          pcpg_pkg::I2C_WDATA: begin
            if (bitcnt == 4'h8) begin
              wr_stb <= 1'b1;
              i2c_sda_oe_out <= 1'b1;
              state <= pcpg_pkg::I2C_ACK_W;
            end
          end
          pcpg_pkg::I2C_ACK_W: begin
            bitcnt <= 4'h0;
            ptr <= ptr + 8'h01;
            i2c_sda_oe_out <= 1'b0;
            state <= pcpg_pkg::I2C_WDATA;
          end
          pcpg_pkg::I2C_RDATA: begin
            if (bitcnt == 4'h8) begin
              i2c_sda_oe_out <= 1'b0;
              ptr <= ptr + 8'h01;
              state <= pcpg_pkg::I2C_ACK_R;
            end else begin
              tx <= {tx[6:0], 1'b0};
              i2c_sda_oe_out <= ~tx[6];
            end
          end
          pcpg_pkg::I2C_ACK_R: begin
            bitcnt <= 4'h0;
            if (shift[0]) begin
              state <= pcpg_pkg::I2C_IDLE;
            end else begin
              tx <= rd_data;
              i2c_sda_oe_out <= ~rd_data[7];
              state <= pcpg_pkg::I2C_RDATA;
            end
          end
          default: begin
            state <= pcpg_pkg::I2C_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] device_config;
  logic [7:0] ext_clock_sync_control;
  logic [7:0] power_good_output_control;
  logic [7:0] power_good_gating_control;
  logic [1:0] fault;
  logic sync_int;
  logic sw_reset;
  logic clk_present;
  logic clk_present_d;
  logic [5:0] loss_cnt;
  logic [1:0] reg_on;

  wire logic wr_cfg = wr_stb & (ptr == `PCPG_ADDR_DEVICE_CONFIG);
  wire logic wr_pll = wr_stb & (ptr == `PCPG_ADDR_EXT_CLOCK);
  wire logic wr_pg1 = wr_stb & (ptr == `PCPG_ADDR_PG_OUTPUT);
  wire logic wr_pg2 = wr_stb & (ptr == `PCPG_ADDR_PG_GATING);
  wire logic wr_fault = wr_stb & (ptr == `PCPG_ADDR_POWER_GOOD_FAULT_LATCHES);
  wire logic wr_rst = wr_stb & (ptr == `PCPG_ADDR_SW_RESET);
  wire logic wr_int = wr_stb & (ptr == `PCPG_ADDR_INT_STATUS);
  wire logic reload = sys_rst_in | sw_reset;

  assign rd_data =
    (ptr == `PCPG_ADDR_DEVICE_CONFIG) ? device_config :
    (ptr == `PCPG_ADDR_EXT_CLOCK) ? ext_clock_sync_control :
    (ptr == `PCPG_ADDR_PG_OUTPUT) ? power_good_output_control :
    (ptr == `PCPG_ADDR_PG_GATING) ? power_good_gating_control :
    (ptr == `PCPG_ADDR_POWER_GOOD_FAULT_LATCHES) ? {6'h00, fault} :
    (ptr == `PCPG_ADDR_INT_STATUS) ? {3'h0, sync_int, 4'h0} : 8'h00;

  wire logic pll_en = ext_clock_sync_control[`PCPG_PLL_ENABLE];
  wire logic external_clock_pin_sel = device_config[`PCPG_CFG_EXTERNAL_CLOCK_PIN_SEL];

  // Configuration reload from nonvolatile values.
  always_ff @(posedge clk_in) begin
    if (reload) begin
      device_config <= nvm_config_in & `PCPG_MASK_CONFIG; // [R21]
      ext_clock_sync_control <= nvm_ext_clock_in & `PCPG_MASK_EXT_CLOCK; // [R21]
      power_good_output_control <= nvm_pg_output_in & `PCPG_MASK_PG_OUTPUT; // [R21]
      power_good_gating_control <= nvm_pg_gating_in & `PCPG_MASK_PG_GATING; // [R21]
    end else begin
      if (wr_cfg) begin
        device_config <= shift & `PCPG_MASK_CONFIG;
      end
      if (wr_pll) begin
        ext_clock_sync_control <= shift & `PCPG_MASK_EXT_CLOCK; // [R9] [R10]
      end
      if (wr_pg1) begin
        power_good_output_control <= shift & `PCPG_MASK_PG_OUTPUT;
      end
      if (wr_pg2) begin
        power_good_gating_control <= shift & `PCPG_MASK_PG_GATING;
      end
    end
  end

  // Software reset pulse clears itself after one cycle.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= wr_rst & shift[`PCPG_SW_RESET_BIT]; // [R21]
    end
  end

  // ----------------------------------------------------------------
  // External clock detection
  // ----------------------------------------------------------------
  wire logic ext_edge = ext_clk_s & ~clk_d;
  wire logic clk_watch = pll_en & external_clock_pin_sel; // [R7] [R8]
  wire logic clk_event = clk_present ^ clk_present_d;

  always_ff @(posedge clk_in) begin
    if (reload) begin
      loss_cnt <= 6'h00;
      clk_present <= 1'b0;
      clk_present_d <= 1'b0;
      sync_int <= 1'b0;
    end else begin
      clk_present_d <= clk_present;
      if (!clk_watch) begin
        loss_cnt <= 6'h00;
        clk_present <= 1'b0; // [R7]
      end else if (ext_edge) begin
        loss_cnt <= 6'h00;
        clk_present <= 1'b1; // [R8]
      end else if (loss_cnt == 6'(`PCPG_EXT_CLK_LOSS_CYCLES)) begin
        clk_present <= 1'b0; // [R8]
      end else begin
        loss_cnt <= loss_cnt + 6'h01;
      end
      sync_int <= (clk_event & pll_en) | (sync_int & ~(wr_int & shift[`PCPG_INT_SYNC_CLK])); // [R20]
    end
  end

  // ----------------------------------------------------------------
  // Regulator delay timers
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_delay
      pcpg_delay_timer #(
        .STEP_CYCLES(DELAY_STEP_CYCLES)
      ) u_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(enable_s),
        .startup_code_in(delay_codes_in[8*gi+3 -: 4]), // [R18]
        .shutdown_code_in(delay_codes_in[8*gi+7 -: 4]), // [R18]
        .startup_range_in(device_config[`PCPG_CFG_STARTUP_RANGE]), // [R1]
        .shutdown_range_in(device_config[`PCPG_CFG_SHUTDOWN_RANGE]), // [R2]
        .on_out(reg_on[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power-good evaluation
  // ----------------------------------------------------------------
  wire logic window = power_good_output_control[`PCPG_PG1_WINDOW];
  wire logic run_cont = power_good_gating_control[`PCPG_PG2_RUN_MODE];
  wire logic [1:0] valid = ~uv_s & ~({2{window}} & ov_s); // [R13]
  wire logic [1:0] watched = power_good_output_control[1:0] & (reg_on | {2{run_cont}}); // [R14] [R17]
  wire logic [1:0] failing = watched & ~valid;
  wire logic [1:0] fault_clr = {2{wr_fault}} & shift[1:0] & valid;
  wire logic [1:0] next_fault = failing | (fault & ~fault_clr); // [R19]
  wire logic live_good = ~|failing;
  wire logic latch_good = ~|fault;
  wire logic gated_good = power_good_gating_control[`PCPG_PG2_FAULT_GATE] ? latch_good : live_good; // [R16]
  wire logic thermal_block = power_good_gating_control[`PCPG_PG2_THERMAL_GATE] & twarn_s; // [R15]
  wire logic next_level = (gated_good & ~thermal_block) ^ power_good_output_control[`PCPG_PG1_POLARITY]; // [R11]
  wire logic open_drain = power_good_output_control[`PCPG_PG1_OPEN_DRAIN];

  always_ff @(posedge clk_in) begin
    if (reload) begin
      fault <= 2'h0;
      power_good_output_out <= 1'b0;
      power_good_output_oe_out <= 1'b0;
      external_clock_pin_out <= 1'b0;
      external_clock_pin_oe_out <= 1'b0;
    end else begin
      fault <= next_fault; // [R19]
      power_good_output_out <= open_drain ? 1'b0 : next_level; // [R12]
      power_good_output_oe_out <= open_drain ? ~next_level : 1'b1; // [R12]
      external_clock_pin_out <= general_output_two_level_in; // [R3]
      external_clock_pin_oe_out <= ~external_clock_pin_sel; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign external_clock_pin_pulldown_enable_out = device_config[`PCPG_CFG_EXTERNAL_CLOCK_PIN_PULLDOWN_ENABLE]; // [R3]
  assign enable_pin_pulldown_out = device_config[`PCPG_CFG_ENABLE_PIN_PULLDOWN]; // [R4]
  assign thermal_warn_level_out = device_config[`PCPG_CFG_TWARN_LEVEL]; // [R5]
  assign spread_spectrum_enable_out = device_config[`PCPG_CFG_SPREAD]; // [R6]
  assign ext_clock_pll_enable_out = ext_clock_sync_control[`PCPG_PLL_ENABLE]; // [R7]
  assign ext_clock_select_out = clk_present; // [R8]
  assign ext_clock_frequency_out = ext_clock_sync_control[4:0]; // [R10]
  assign sync_clock_event_out = sync_int; // [R20]
  assign regulator_enable_out = reg_on;
  assign power_good_fault_latches_out = fault;

endmodule

`default_nettype wire

/* verification/pcpg_regs_assertions.sv */
// Concurrent checks on the register group ports.
`timescale 1ns/1ps
`default_nettype none
module pcpg_regs_check (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic i2c_scl_in,
  input wire logic [7:0] nvm_config_in,
  input wire logic [7:0] nvm_ext_clock_in,
  input wire logic external_clock_pin_oe_out,
  input wire logic external_clock_pin_pulldown_enable_out,
  input wire logic enable_pin_pulldown_out,
  input wire logic thermal_warn_level_out,
  input wire logic spread_spectrum_enable_out,
  input wire logic ext_clock_pll_enable_out,
  input wire logic ext_clock_select_out,
  input wire logic [4:0] ext_clock_frequency_out,
  input wire logic sync_clock_event_out,
  input wire logic [1:0] power_good_fault_latches_out,
  input wire logic power_good_output_out,
  input wire logic power_good_output_oe_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  pg_drive_a: assert property (power_good_output_out |-> power_good_output_oe_out)
    else $error("power-good high level without drive");
  pll_gate_a: assert property (!ext_clock_pll_enable_out [*3] |-> !ext_clock_select_out)
    else $error("external clock used with pll off");
  pin_func_a: assert property (external_clock_pin_oe_out [*3] |-> !ext_clock_select_out)
    else $error("external clock used while pin is an output");
  event_src_a: assert property ($rose(sync_clock_event_out) |->
    $past(ext_clock_pll_enable_out) || $past(ext_clock_pll_enable_out, 2))
    else $error("clock event raised with pll off");
  event_hold_a: assert property ((i2c_scl_in [*6]) ##0 sync_clock_event_out |=>
    sync_clock_event_out)
    else $error("clock event dropped without a bus write");
  cfg_stable_a: assert property (i2c_scl_in [*6] |=> $stable({enable_pin_pulldown_out,
    thermal_warn_level_out, spread_spectrum_enable_out, ext_clock_frequency_out}))
    else $error("configuration output changed without a bus write");
  latch_hold_a: assert property (i2c_scl_in [*6] |=>
    (power_good_fault_latches_out & $past(power_good_fault_latches_out)) ==
    $past(power_good_fault_latches_out))
    else $error("fault latch cleared without a bus write");
  nvm_load_a: assert property (disable iff (1'b0) sys_rst_in |=>
    {ext_clock_pll_enable_out, ext_clock_frequency_out, external_clock_pin_pulldown_enable_out,
    enable_pin_pulldown_out, thermal_warn_level_out, spread_spectrum_enable_out} ==
    {$past(nvm_ext_clock_in[6]), $past(nvm_ext_clock_in[4:0]), $past(nvm_config_in[3:0])})
    else $error("configuration outputs differ from stored values after reset");
endmodule
bind pcpg_regs pcpg_regs_check pcpg_regs_check_inst (.*);
`default_nettype wire

/* verification/pcpg_i2c_host.sv */
// Two-wire serial host model driving the clock line and pulling data low.
`timescale 1ns/1ps
`default_nettype none
module pcpg_i2c_host (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #100 sda_low_out = !b;
    #300 scl_out = 1'b1;
    #400 r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic start();
    #100 sda_low_out = 1'b0;
    #300 scl_out = 1'b1;
    #400 sda_low_out = 1'b1;
    #400 scl_out = 1'b0;
  endtask
  task automatic stop();
    #100 sda_low_out = 1'b1;
    #300 scl_out = 1'b1;
    #400 sda_low_out = 1'b0;
    #400;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic nack, output logic [7:0] rx,
      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], a);
      rx[i] = a;
    end
    bit_io(nack, a);
    ack = !a;
  endtask
endmodule
`default_nettype wire

/* verification/test_pcpg_regs.sv */
// Self-checking bench for the register group.
`timescale 1ns/1ps
`default_nettype none
module test_pcpg_regs;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clk_in, sys_rst_in, i2c_scl_in, i2c_sda_out, i2c_sda_oe_out, host_low;
  logic [7:0] nvm_config_in, nvm_ext_clock_in, nvm_pg_output_in, nvm_pg_gating_in;
  logic [15:0] delay_codes_in;
  logic [1:0] reg_undervoltage_in, reg_overvoltage_in, regulator_enable_out;
  logic enable_pin_in, thermal_warn_in, external_clock_pin_in, general_output_two_level_in;
  logic external_clock_pin_out, external_clock_pin_oe_out, external_clock_pin_pulldown_enable_out;
  logic enable_pin_pulldown_out, thermal_warn_level_out, spread_spectrum_enable_out;
  logic ext_clock_pll_enable_out, ext_clock_select_out, sync_clock_event_out, ext_run;
  logic [4:0] ext_clock_frequency_out;
  logic [1:0] power_good_fault_latches_out;
  logic power_good_output_out, power_good_output_oe_out;
  logic [7:0] d;
  logic k;
  int miscompares = 0;
  int total_checks = 0;
  wire logic i2c_sda_in = !(host_low | i2c_sda_oe_out);
  pcpg_regs #(.I2C_ADDRESS(ADDR), .DELAY_STEP_CYCLES(16'h0014)) pcpg_regs_inst (.*);
  pcpg_i2c_host pcpg_i2c_host_inst (.sda_in(i2c_sda_in), .scl_out(i2c_scl_in),
    .sda_low_out(host_low));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always #200 if (ext_run) external_clock_pin_in = !external_clock_pin_in;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    pcpg_i2c_host_inst.start();
    pcpg_i2c_host_inst.byte_io({ADDR, 1'b0}, 1'b1, d, k);
    pcpg_i2c_host_inst.byte_io(a, 1'b1, d, k);
    pcpg_i2c_host_inst.byte_io(v, 1'b1, d, k);
    pcpg_i2c_host_inst.stop();
  endtask
  task automatic rd(input logic [7:0] a);
    pcpg_i2c_host_inst.start();
    pcpg_i2c_host_inst.byte_io({ADDR, 1'b0}, 1'b1, d, k);
    pcpg_i2c_host_inst.byte_io(a, 1'b1, d, k);
    pcpg_i2c_host_inst.start();
    pcpg_i2c_host_inst.byte_io({ADDR, 1'b1}, 1'b1, d, k);
    pcpg_i2c_host_inst.byte_io(8'hff, 1'b1, d, k);
    pcpg_i2c_host_inst.stop();
  endtask
  task automatic wait_sel(input logic e);
    int n;
    n = 0;
    while (ext_clock_select_out !== e && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    chk({7'h00, ext_clock_select_out}, {7'h00, e});
  endtask
  task automatic pg(input logic [7:0] c1, input logic [7:0] c2, input logic [4:0] ins,
      input logic [1:0] e);
    wr(8'h15, c1);
    wr(8'h16, c2);
    @(negedge clk_in);
    {thermal_warn_in, reg_overvoltage_in, reg_undervoltage_in} = ins;
    repeat (6) @(negedge clk_in);
    chk({6'h00, power_good_output_out, power_good_output_oe_out}, {6'h00, e});
  endtask
  task automatic dly(input logic rng, input int lo);
    int n;
    wr(8'h13, {1'b0, rng, 6'h00});
    @(negedge clk_in);
    enable_pin_in = 1'b1;
    n = 0;
    while (regulator_enable_out[0] !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    chk(8'(n >= lo && n <= lo + 6), 8'h01);
    enable_pin_in = 1'b0;
    repeat (10) @(negedge clk_in);
  endtask
  task automatic regs_reset();
    logic [7:0] m [4];
    m = '{8'h7f, 8'h5f, 8'hd3, 8'h07};
    for (int i = 0; i < 4; i++) begin
      rd(8'h13 + 8'(i));
      chk(d, m[i]);
    end
    rd(8'h1a);
    chk(d, 8'h00);
    pcpg_i2c_host_inst.start();
    pcpg_i2c_host_inst.byte_io({ADDR ^ 7'h01, 1'b0}, 1'b1, d, k);
    pcpg_i2c_host_inst.stop();
    chk({7'h00, k}, 8'h00);
  endtask
  task automatic cfg_bits();
    logic [7:0] v [2];
    v = '{8'h05, 8'h1a};
    for (int i = 0; i < 2; i++) begin
      wr(8'h13, v[i]);
      chk({2'h0, external_clock_pin_out, external_clock_pin_oe_out, external_clock_pin_pulldown_enable_out,
        enable_pin_pulldown_out, thermal_warn_level_out, spread_spectrum_enable_out},
        {2'h0, 1'b1, ~v[i][4], v[i][3:0]});
    end
  endtask
  task automatic ext_clock();
    wr(8'h14, 8'h17);
    chk({3'h0, ext_clock_frequency_out}, 8'h17);
    ext_run = 1'b1;
    repeat (100) @(negedge clk_in);
    chk({7'h00, ext_clock_select_out}, 8'h00);
    wr(8'h14, 8'h40);
    wait_sel(1'b1);
    chk({7'h00, sync_clock_event_out}, 8'h01);
    ext_run = 1'b0;
    wait_sel(1'b0);
    wr(8'h19, 8'h10);
    chk({7'h00, sync_clock_event_out}, 8'h00);
  endtask
  task automatic power_good();
    enable_pin_in = 1'b1;
    pg(8'h03, 8'h00, 5'b00000, 2'b11);
    pg(8'h03, 8'h00, 5'b01000, 2'b11);
    pg(8'h13, 8'h00, 5'b01000, 2'b01);
    pg(8'h01, 8'h00, 5'b00010, 2'b11);
    pg(8'hc1, 8'h00, 5'b00000, 2'b01);
    pg(8'hc1, 8'h00, 5'b00001, 2'b00);
    pg(8'h03, 8'h04, 5'b10000, 2'b01);
    pg(8'h03, 8'h00, 5'b10000, 2'b11);
    chk({6'h00, power_good_fault_latches_out}, 8'h03);
    wr(8'h17, 8'h03);
    chk({6'h00, power_good_fault_latches_out}, 8'h00);
    reg_undervoltage_in = 2'b01;
    repeat (6) @(negedge clk_in);
    pg(8'h03, 8'h02, 5'b00000, 2'b01);
    wr(8'h17, 8'h03);
    enable_pin_in = 1'b0;
    pg(8'h03, 8'h00, 5'b00001, 2'b11);
    pg(8'h03, 8'h01, 5'b00001, 2'b01);
  endtask
  initial begin
    {sys_rst_in, nvm_config_in, nvm_ext_clock_in} = {1'b1, 16'hffff};
    {nvm_pg_output_in, nvm_pg_gating_in, delay_codes_in} = 32'hffff_0000;
    {reg_undervoltage_in, reg_overvoltage_in, thermal_warn_in, enable_pin_in} = 6'h00;
    {external_clock_pin_in, ext_run, general_output_two_level_in} = 3'b001;
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    regs_reset();
    cfg_bits();
    ext_clock();
    power_good();
    delay_codes_in = 16'h0003;
    dly(1'b0, 60);
    dly(1'b1, 120);
    wr(8'h18, 8'h01);
    rd(8'h13);
    chk(d, 8'h7f);
    results();
  end
endmodule
`default_nettype wire
